// ===== src/mic_irq_controller.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - five hardware sources plus one software trap instruction
// - hardware vectoring only while global enable set (irq output ignores it); enable/disable instructions steer it
// - trap always vectors to 0x001 and clears global enable
// - return instruction sets global enable and resumes program
// - events set sticky pending flags; firmware clears by writing zero
// - pending flag reads as set only when its enable bit is one
// - enabled pending flag with global enable vectors to 0x008, clears enable
// - timer 0 overflow sets its flag, serviced with its enable
// - timer 1 underflow sets its flag, serviced with its enable
// - watchdog timeout flags only in interrupt mode
// - selected input pins of port b flag any level change
// - edge select removes pin zero from change detection
// - chosen edge on pin zero sets external flag
// - timer 0 at bit 0, timer 1 bit 3, watchdog bit 6
module mic_irq_controller
    import mic_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    input  wire logic [3:0]  avsByteenable,
    output logic      [31:0] avsReaddata,
    output logic             avsWaitrequest,
    // sequencer
    input  wire logic [2:0]  seqOp,
    input  wire logic        seqBoundary,
    output logic             vectorTake,
    output logic      [9:0]  vectorAddr,
    output logic             globalIrqEnable,
    // peripheral events, same clock
    input  wire logic        timer0Overflow,
    input  wire logic        timer1Underflow,
    input  wire logic        watchdogTimeout,
    // port b pins
    input  wire logic [7:0]  portBPins,
    // cpu-side interrupt
    output logic             irq
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [7:0]  pending_q, pending_d;
    logic [7:0]  enable_q, enable_d;
    logic [31:0] control_q, control_d;
    logic        gie_q, gie_d;
    logic        serv_q, serv_d;
    logic        take_q, take_d;
    logic [9:0]  vec_q, vec_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic [7:0]  pinMeta_q, pinSync_q;
    logic [7:0]  events;
    logic        hwRequest;
    logic        access;

    mic_event_if evBus ();

    // --------------------------------------------------------------
    // pin synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_q <= 8'h00;
            pinSync_q <= 8'h00;
        end else begin
            pinMeta_q <= portBPins;
            pinSync_q <= pinMeta_q;
        end
    end

    mic_pin_detect uDetect (
        .clk                  (clk),
        .rst                  (rst),
        .portBSync            (pinSync_q),
        .portBIsInput         (control_q[CTL_DIR_LO +: 8]),
        .portBChangeSelect    (control_q[CTL_SEL_LO +: 8]),
        .externalEdgeSelect   (control_q[CTL_EDGE_SEL]),
        .externalEdgePolarity (control_q[CTL_EDGE_POL]),
        .ev                   (evBus.src),
        .timer0OvfIn          (timer0Overflow),
        .timer1UdfIn          (timer1Underflow),
        .watchdogToIn         (watchdogTimeout),
        .watchdogIrqMode      (control_q[CTL_WDT_IRQ])
    );

    // --------------------------------------------------------------
    // event collection
    // --------------------------------------------------------------
    always_comb begin
        events          = 8'h00;
        events[BIT_T0]  = evBus.timer0Ovf;
        events[BIT_T1]  = evBus.timer1Udf;
        events[BIT_WDT] = evBus.watchdogTo;
        events[BIT_PB]  = evBus.portChange;
        events[BIT_EXT] = evBus.extEdge;
    end

    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        merge8 = be[0] ? wd[7:0] : old;
    endfunction

    assign access = (avsRead | avsWrite) & ~ack_q;
    // one hardware vector for all sources; firmware polls the flags
    assign hwRequest = |(pending_q & enable_q) & gie_q;

    // --------------------------------------------------------------
    // flags, enables, control and bus
    // --------------------------------------------------------------
    always_comb begin
        pending_d = pending_q;
        enable_d  = enable_q;
        control_d = control_q;
        rdata_d   = rdata_q;
        ack_d     = access;
        if (access && avsWrite) begin
            unique case (avsAddress)
                ADDR_PENDING: begin
                    // writing zero clears; writing one leaves the flag
                    pending_d = pending_q & merge8(8'hFF, avsWritedata, avsByteenable);
                end
                ADDR_ENABLE: begin
                    enable_d = merge8(enable_q, avsWritedata, avsByteenable) & SRC_MASK;
                end
                ADDR_CONTROL: begin
                    for (int b = 0; b < 4; b++) begin
                        if (avsByteenable[b]) begin
                            control_d[b*8 +: 8] = avsWritedata[b*8 +: 8];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // set wins over a simultaneous clear
        pending_d = (pending_d | events) & SRC_MASK;
        if (access && avsRead) begin
            unique case (avsAddress)
                ADDR_PENDING: rdata_d = {24'h0, pending_q & enable_q};
                ADDR_ENABLE:  rdata_d = {24'h0, enable_q};
                ADDR_CONTROL: rdata_d = control_q;
                ADDR_STATUS:  rdata_d = {30'h0, serv_q, gie_q};
                default:      rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending_q <= PENDING_RST;
            enable_q  <= ENABLE_RST;
            control_q <= CONTROL_RST;
            rdata_q   <= 32'h0000_0000;
            ack_q     <= 1'b0;
        end else begin
            pending_q <= pending_d;
            enable_q  <= enable_d;
            control_q <= control_d;
            rdata_q   <= rdata_d;
            ack_q     <= ack_d;
        end
    end

    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_q;
    assign avsReaddata    = rdata_q;

    // --------------------------------------------------------------
    // global enable and vector redirection
    // --------------------------------------------------------------
    always_comb begin
        gie_d  = gie_q;
        serv_d = serv_q;
        take_d = 1'b0;
        vec_d  = vec_q;
        if (seqBoundary) begin
            unique case (mic_op_e'(seqOp))
                MIC_OP_ENABLE:  gie_d = 1'b1;
                MIC_OP_DISABLE: gie_d = 1'b0;
                MIC_OP_RETURN: begin
                    gie_d  = 1'b1;
                    serv_d = 1'b0;
                end
                default: begin
                end
            endcase
            if (mic_op_e'(seqOp) == MIC_OP_TRAP) begin
                // trap ignores the global enable
                take_d = 1'b1;
                vec_d  = VEC_SOFT;
                gie_d  = 1'b0;
                serv_d = 1'b1;
            end else if (hwRequest && mic_op_e'(seqOp) != MIC_OP_DISABLE) begin
                take_d = 1'b1;
                vec_d  = VEC_HARD;
                gie_d  = 1'b0;
                serv_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gie_q  <= 1'b0;
            serv_q <= 1'b0;
            take_q <= 1'b0;
            vec_q  <= 10'h000;
        end else begin
            gie_q  <= gie_d;
            serv_q <= serv_d;
            take_q <= take_d;
            vec_q  <= vec_d;
        end
    end

    assign vectorTake      = take_q;
    assign vectorAddr      = vec_q;
    assign globalIrqEnable = gie_q;
    assign irq             = |(pending_q & enable_q);
endmodule
`default_nettype wire

// ===== src/mic_pkg.sv
package mic_pkg;
    // --------------------------------------------------------------
    // register map (byte addresses, one word each)
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_PENDING = 4'h0;
    localparam logic [3:0] ADDR_ENABLE  = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'hC;

    // --------------------------------------------------------------
    // pending / enable field positions
    // --------------------------------------------------------------
    localparam int BIT_T0  = 0;
    localparam int BIT_PB  = 1;
    localparam int BIT_EXT = 2;
    localparam int BIT_T1  = 3;
    localparam int BIT_WDT = 6;
    localparam logic [7:0] SRC_MASK = 8'h4F;

    // control register fields
    localparam int CTL_EDGE_SEL  = 0;
    localparam int CTL_EDGE_POL  = 1;
    localparam int CTL_WDT_IRQ   = 2;
    localparam int CTL_SEL_LO    = 8;
    localparam int CTL_DIR_LO    = 16;

    // status register fields
    localparam int STS_GIE       = 0;
    localparam int STS_IN_SERV   = 1;

    // --------------------------------------------------------------
    // vectors and reset values
    // --------------------------------------------------------------
    localparam logic [9:0] VEC_SOFT = 10'h001;
    localparam logic [9:0] VEC_HARD = 10'h008;
    localparam logic [7:0] PENDING_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST  = 8'h00;
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;

    // instruction codes presented by the sequencer
    typedef enum logic [2:0] {
        MIC_OP_NONE   = 3'b000,
        MIC_OP_ENABLE = 3'b001,
        MIC_OP_DISABLE= 3'b010,
        MIC_OP_RETURN = 3'b011,
        MIC_OP_TRAP   = 3'b100
    } mic_op_e;
endpackage

// ===== src/mic_event_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mic_event_if;
    logic       timer0Ovf;
    logic       timer1Udf;
    logic       watchdogTo;
    logic       portChange;
    logic       extEdge;
    modport src (output timer0Ovf, timer1Udf, watchdogTo, portChange, extEdge);
    modport dst (input  timer0Ovf, timer1Udf, watchdogTo, portChange, extEdge);
endinterface
`default_nettype wire

// ===== src/mic_pin_detect.sv
`timescale 1ns/1ps
`default_nettype none
module mic_pin_detect
    import mic_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // port b pins, already synchronised
    input  wire logic [7:0] portBSync,
    input  wire logic [7:0] portBIsInput,
    input  wire logic [7:0] portBChangeSelect,
    input  wire logic       externalEdgeSelect,
    input  wire logic       externalEdgePolarity,
    // events
    mic_event_if.src        ev,
    input  wire logic       timer0OvfIn,
    input  wire logic       timer1UdfIn,
    input  wire logic       watchdogToIn,
    input  wire logic       watchdogIrqMode
);
    logic [7:0] prev_q;
    logic [7:0] prev_d;
    logic [7:0] watch;

    always_comb begin
        prev_d = portBSync;
        watch  = portBIsInput & portBChangeSelect;
        // edge input owns pin zero when selected
        if (externalEdgeSelect) begin
            watch[0] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 8'h00;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign ev.portChange = |((prev_q ^ portBSync) & watch);
    // polarity 1 = rising, 0 = falling
    assign ev.extEdge    = externalEdgeSelect & (externalEdgePolarity ?
                           (portBSync[0] & ~prev_q[0]) : (~portBSync[0] & prev_q[0]));
    assign ev.timer0Ovf  = timer0OvfIn;
    assign ev.timer1Udf  = timer1UdfIn;
    assign ev.watchdogTo = watchdogToIn & watchdogIrqMode;
endmodule
`default_nettype wire

// ===== verif/mic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
    import mic_pkg::*;
(
    // clock and fetch feedback
    input  wire logic       clk,
    input  wire logic       vectorTake,
    input  wire logic [9:0] vectorAddr,
    input  wire logic       globalIrqEnable,
    // sequencer and sources
    output var  logic [2:0] seqOp,
    output var  logic       seqBoundary,
    output var  logic       timer0Overflow,
    output var  logic       timer1Underflow,
    output var  logic       watchdogTimeout,
    output var  logic [7:0] portBPins
);
    initial begin
        {seqOp, seqBoundary, timer0Overflow, timer1Underflow, watchdogTimeout} = 7'h00;
        portBPins = 8'h00;
    end
    // one instruction ends; enable is never sent right before return
    task automatic step(input logic [2:0] op, output logic tk, output logic [9:0] va,
                        output logic ge);
        @(posedge clk);
        seqOp       <= op;
        seqBoundary <= 1'b1;
        @(posedge clk);
        seqOp       <= MIC_OP_NONE;
        seqBoundary <= 1'b0;
        @(posedge clk);
        tk = vectorTake;
        va = vectorAddr;
        ge = globalIrqEnable;
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        timer0Overflow  <= (k == 0);
        timer1Underflow <= (k == 1);
        watchdogTimeout <= (k == 2);
        @(posedge clk);
        {timer0Overflow, timer1Underflow, watchdogTimeout} <= 3'b000;
    endtask
    task automatic pins(input logic [7:0] v);
        @(posedge clk);
        portBPins <= v;
    endtask
endmodule
`default_nettype wire

// ===== verif/mic_irq_controller_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mic_irq_sva
    import mic_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // sequencer side
    input wire logic [2:0] seqOp,
    input wire logic       seqBoundary,
    input wire logic       vectorTake,
    input wire logic [9:0] vectorAddr,
    input wire logic       globalIrqEnable,
    input wire logic       irq,
    // bus handshake
    input wire logic       avsRead,
    input wire logic       avsWrite,
    input wire logic       avsWaitrequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_trap_vector: assert property (seqBoundary && seqOp == MIC_OP_TRAP
        |=> vectorTake && vectorAddr == VEC_SOFT) else $error("trap vector wrong");
    a_trap_gie: assert property (seqBoundary && seqOp == MIC_OP_TRAP
        |=> !globalIrqEnable) else $error("trap kept enable");
    a_enable_sets: assert property (seqBoundary && seqOp == MIC_OP_ENABLE
        && !globalIrqEnable |=> globalIrqEnable) else $error("enable ignored");
    a_disable_clears: assert property (seqBoundary && seqOp == MIC_OP_DISABLE
        |=> !globalIrqEnable) else $error("disable ignored");
    a_return_sets: assert property (seqBoundary && seqOp == MIC_OP_RETURN
        && !globalIrqEnable |=> globalIrqEnable) else $error("return kept off");
    a_hw_vector: assert property (seqBoundary && seqOp == MIC_OP_NONE && globalIrqEnable
        && irq |=> vectorTake && vectorAddr == VEC_HARD && !globalIrqEnable)
        else $error("hardware take wrong");
    a_gated_gie: assert property (seqBoundary && !globalIrqEnable
        && seqOp != MIC_OP_TRAP |=> !vectorTake) else $error("take while off");
    a_take_boundary: assert property (vectorTake |-> $past(seqBoundary))
        else $error("take off boundary");
    a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitrequest
        |=> !avsWaitrequest) else $error("bus answer late");
    c_trap: cover property (seqBoundary && seqOp == MIC_OP_TRAP && globalIrqEnable);
    c_hw: cover property (vectorTake && vectorAddr == VEC_HARD);
    c_enable: cover property (seqBoundary && seqOp == MIC_OP_ENABLE);
endmodule
bind mic_irq_controller mic_irq_sva mic_irq_sva_inst (.clk(clk), .rst(rst), .seqOp(seqOp),
    .seqBoundary(seqBoundary), .vectorTake(vectorTake), .vectorAddr(vectorAddr),
    .globalIrqEnable(globalIrqEnable), .irq(irq), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWaitrequest(avsWaitrequest));
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mic_pkg::*;
    logic clk, rst, avsRead, avsWrite, avsWaitrequest, seqBoundary, vectorTake, irq;
    logic globalIrqEnable, timer0Overflow, timer1Underflow, watchdogTimeout, tk, ge;
    logic [3:0] avsAddress, avsByteenable;
    logic [31:0] avsWritedata, avsReaddata, q;
    logic [2:0] seqOp;
    logic [9:0] vectorAddr, va;
    logic [7:0] portBPins;
    int failures, checks;
    int bits[3] = '{BIT_T0, BIT_T1, BIT_WDT};
    mic_irq_controller mic_irq_controller_inst (.clk(clk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest),
        .seqOp(seqOp), .seqBoundary(seqBoundary), .vectorTake(vectorTake),
        .vectorAddr(vectorAddr), .globalIrqEnable(globalIrqEnable),
        .timer0Overflow(timer0Overflow), .timer1Underflow(timer1Underflow),
        .watchdogTimeout(watchdogTimeout), .portBPins(portBPins), .irq(irq));
    mic_core_model mic_core_model_inst (.clk(clk), .vectorTake(vectorTake),
        .vectorAddr(vectorAddr), .globalIrqEnable(globalIrqEnable), .seqOp(seqOp),
        .seqBoundary(seqBoundary), .timer0Overflow(timer0Overflow),
        .timer1Underflow(timer1Underflow), .watchdogTimeout(watchdogTimeout),
        .portBPins(portBPins));
    task automatic finish_test();
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // a hang in the handshake ends the run
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be = 4'hF);
        int n;
        @(posedge clk);
        avsAddress    <= a;
        avsWritedata  <= d;
        avsByteenable <= be;
        avsWrite     <= wr;
        avsRead      <= ~wr;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (avsWaitrequest === 1'b0) break;
        end
        if (n == 16) begin
            failures++;
            finish_test();
        end
        q = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk("readdata", exp, q);
    endtask
    task automatic seq(input logic [2:0] op, input logic etk, input logic [9:0] eva,
                       input logic ege);
        mic_core_model_inst.step(op, tk, va, ge);
        chk("take", {31'h0, etk}, {31'h0, tk});
        if (etk) chk("vector", {22'h0, eva}, {22'h0, va});
        chk("gie", {31'h0, ege}, {31'h0, ge});
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, avsRead, avsWrite, avsAddress, avsWritedata} = {1'b1, 38'h0};
        avsByteenable = 4'hF;
        failures = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_PENDING, 32'h0);
        rd(ADDR_CONTROL, CONTROL_RST);
        rd(4'h2, 32'h0);
        bus(1'b1, ADDR_ENABLE, 32'hFF);
        rd(ADDR_ENABLE, {24'h0, SRC_MASK});
        // lane 0 off: the enable byte must stay as it was
        bus(1'b1, ADDR_ENABLE, 32'h0, 4'hE);
        rd(ADDR_ENABLE, {24'h0, SRC_MASK});
        mic_core_model_inst.pulse(2);
        rd(ADDR_PENDING, 32'h0);
        bus(1'b1, ADDR_CONTROL, 32'h4);
        for (int i = 0; i < 3; i++) begin
            mic_core_model_inst.pulse(i);
            rd(ADDR_PENDING, 32'h1 << bits[i]);
            chk("irq", 32'h1, {31'h0, irq});
            bus(1'b1, ADDR_PENDING, 32'h0);
            rd(ADDR_PENDING, 32'h0);
        end
        // flag kept but hidden while its enable is off
        mic_core_model_inst.pulse(0);
        bus(1'b1, ADDR_ENABLE, 32'h0);
        rd(ADDR_PENDING, 32'h0);
        bus(1'b1, ADDR_ENABLE, 32'h1);
        rd(ADDR_PENDING, 32'h1);
        seq(MIC_OP_NONE, 1'b0, 10'h0, 1'b0);
        seq(MIC_OP_ENABLE, 1'b0, 10'h0, 1'b1);
        seq(MIC_OP_NONE, 1'b1, VEC_HARD, 1'b0);
        seq(MIC_OP_TRAP, 1'b1, VEC_SOFT, 1'b0);
        seq(MIC_OP_RETURN, 1'b0, 10'h0, 1'b1);
        rd(ADDR_STATUS, 32'h1 << STS_GIE);
        seq(MIC_OP_DISABLE, 1'b0, 10'h0, 1'b0);
        seq(MIC_OP_ENABLE, 1'b0, 10'h0, 1'b1);
        seq(MIC_OP_TRAP, 1'b1, VEC_SOFT, 1'b0);
        rd(ADDR_STATUS, 32'h1 << STS_IN_SERV);
        bus(1'b1, ADDR_ENABLE, 32'h4F);
        bus(1'b1, ADDR_PENDING, 32'h0);
        bus(1'b1, ADDR_CONTROL, 32'h0003_0304);
        mic_core_model_inst.pins(8'h02);
        repeat (4) @(posedge clk);
        rd(ADDR_PENDING, 32'h1 << BIT_PB);
        bus(1'b1, ADDR_PENDING, 32'h0);
        bus(1'b1, ADDR_CONTROL, 32'h0003_0307);
        mic_core_model_inst.pins(8'h03);
        repeat (4) @(posedge clk);
        rd(ADDR_PENDING, 32'h1 << BIT_EXT);
        bus(1'b1, ADDR_PENDING, 32'h0);
        mic_core_model_inst.pins(8'h02);
        repeat (4) @(posedge clk);
        rd(ADDR_PENDING, 32'h0);
        // second reset in mid-run: everything back to its reset value
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_ENABLE, {24'h0, ENABLE_RST});
        rd(ADDR_CONTROL, CONTROL_RST);
        rd(ADDR_STATUS, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
